/* File: bix_exec.sv */
// execution of absolute jump, increment and increment-with-skip
//
// What this block does
// - jump loads nine literal bits into counter
// - jump upper counter bits from status page
// - jump two cycles, one word, flags kept
// - increment_reg adds one to selected register
// - destination bit picks accumulator or register
// - increment_skip_null skips next when result zero
// - skip replaces fetched instruction with idle_op
`timescale 1ns/1ps
module bix_exec
	import bix_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// instruction fetch
	input wire logic [bix_pkg::INSN_W-1:0] insn_i,
	output logic [bix_pkg::PC_W-1:0] program_counter_o,
	// status load from the rest of the core
	input wire logic stat_we_i,
	input wire logic [bix_pkg::DATA_W-1:0] stat_wdata_i,
	// architectural state view
	output logic [bix_pkg::DATA_W-1:0] acc_o,
	output logic [bix_pkg::DATA_W-1:0] status_o,
	output logic [bix_pkg::INSN_W-1:0] exec_insn_o,
	output logic flush_o
);
	import bix_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pipeline: decode stage holds the word fetched last cycle
	bix_state_t state;
	bix_state_t next_state;
	logic [INSN_W-1:0] ir;
	logic [PC_W-1:0] pc;
	logic [DATA_W-1:0] acc;
	logic [DATA_W-1:0] status;
	logic [DATA_W-1:0] rf_rdata;
	logic flush;
	logic [INSN_W-1:0] exec_insn;

	// register read is one cycle ahead: address taken from the fetched word
	wire [FADDR_W-1:0] fetch_faddr = insn_i[FADDR_W-1:0];
	wire flushing = (state == BIX_FLUSH);
	wire [INSN_W-1:0] cur = flushing ? IDLE_OP : ir;
	wire is_jump = cur[INSN_W-1:OPC_JUMP_POS] == OPC_JUMP;
	wire is_inc = cur[INSN_W-1:OPC6_POS] == OPC_INC;
	wire is_incskip = cur[INSN_W-1:OPC6_POS] == OPC_INCSKIP;
	wire dest_reg = cur[DEST_POS];
	wire [FADDR_W-1:0] faddr = cur[FADDR_W-1:0];
	wire [DATA_W-1:0] inc_res = rf_rdata + 8'h01;
	wire inc_zero = (inc_res == 8'h00);
	wire any_inc = is_inc || is_incskip;
	wire do_skip = is_incskip && inc_zero;
	wire [PC_W-1:0] jump_target = {status[STAT_PAGE_HI:STAT_PAGE_LO], cur[LIT_W-1:0]};
	wire [PC_W-1:0] next_pc = is_jump ? jump_target : pc + 11'h001;
	wire rf_we = any_inc && dest_reg;
	wire acc_we = any_inc && !dest_reg;

	////////////////////////////////////////////////////////////////////////
	// state: jump and taken skip both spend one cycle on idle_op
	always_comb begin
		case (state)
			BIX_RUN: begin
				next_state = (is_jump || do_skip) ? BIX_FLUSH : BIX_RUN;
			end
			BIX_FLUSH: begin
				next_state = BIX_RUN;
			end
			default: begin
				next_state = BIX_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			state <= BIX_FLUSH;
			ir <= IDLE_OP;
			pc <= PC_RESET;
		end else begin
			state <= next_state;
			ir <= insn_i;
			pc <= next_pc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// accumulator and status
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			acc <= ACC_RESET;
		end else if (acc_we) begin
			acc <= inc_res;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			status <= STAT_RESET;
		end else if (stat_we_i) begin
			status <= stat_wdata_i;
		end else if (is_inc) begin
			status[STAT_ZERO_POS] <= inc_zero;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			// low in the discard cycle right after reset; only ir is dropped
			flush <= 1'b0;
			exec_insn <= IDLE_OP;
		end else begin
			flush <= (next_state == BIX_FLUSH);
			exec_insn <= cur;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// file registers; back-to-back writes forwarded inside the memory
	bix_regfile #(
		.DEPTH(NREGS),
		.AW(FADDR_W),
		.DW(DATA_W)
	) u_regfile (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.raddr_i(fetch_faddr),
		.rdata_o(rf_rdata),
		.we_i(rf_we),
		.waddr_i(faddr),
		.wdata_i(inc_res)
	);

	assign program_counter_o = pc;
	assign acc_o = acc;
	assign status_o = status;
	assign exec_insn_o = exec_insn;
	assign flush_o = flush;

	////////////////////////////////////////////////////////////////////////
	// checks: jump
	chk_jump_target: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_jump && !stat_we_i |=> pc == {$past(status[STAT_PAGE_HI:STAT_PAGE_LO]), $past(cur[LIT_W-1:0])})
		else $error("jump target wrong");
	chk_jump_page: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_jump |=> pc[PC_W-1:LIT_W] == $past(status[STAT_PAGE_HI:STAT_PAGE_LO]))
		else $error("jump page bits wrong");
	chk_jump_flush: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_jump |=> flushing ##1 !flushing)
		else $error("jump not two cycles");
	chk_jump_flags: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_jump && !stat_we_i |=> status == $past(status))
		else $error("jump changed flags");
	chk_jump_word: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_jump |=> ##1 exec_insn_o == IDLE_OP)
		else $error("word after jump executed");
	chk_jump_resume: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_jump |=> ##1 pc == $past(pc) + 11'h001)
		else $error("jump did not resume at target");

	// checks: increment
	chk_inc_acc: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		acc_we |=> acc == $past(rf_rdata) + 8'h01)
		else $error("accumulator result wrong");
	chk_inc_single: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_inc |=> !flushing)
		else $error("increment took two cycles");
	chk_dest_reg: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		any_inc && dest_reg |=> acc == $past(acc))
		else $error("accumulator written for register dest");
	chk_acc_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!acc_we |=> acc == $past(acc))
		else $error("accumulator changed without write");
	chk_fwd_data: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rf_we && faddr == fetch_faddr |=> rf_rdata == $past(inc_res))
		else $error("register result not written back");
	chk_reg_unwritten: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		any_inc && !dest_reg && faddr == fetch_faddr |=> rf_rdata == $past(rf_rdata))
		else $error("register written for accumulator dest");
	chk_zero_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_inc && !stat_we_i |=> status[STAT_ZERO_POS] == $past(inc_zero))
		else $error("zero flag wrong");
	chk_inc_others: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_inc && !stat_we_i |=> status[DATA_W-1:STAT_ZERO_POS+1] == $past(status[DATA_W-1:STAT_ZERO_POS+1]))
		else $error("increment changed other flags");
	chk_status_keep: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!stat_we_i && !is_inc |=> status == $past(status))
		else $error("status changed without cause");
	chk_stat_load: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		stat_we_i |=> status == $past(stat_wdata_i))
		else $error("status load lost");

	// checks: skip
	chk_skip_flush: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_incskip |=> flushing == $past(inc_zero))
		else $error("skip decision wrong");
	chk_pc_advance: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_incskip |=> pc == $past(pc) + 11'h001)
		else $error("skip moved counter wrongly");
	chk_skip_acc: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_incskip && !dest_reg |=> acc == $past(inc_res))
		else $error("skip result not in accumulator");
	chk_skip_idle: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		do_skip |=> cur == IDLE_OP && !any_inc && !is_jump)
		else $error("skipped word executed");
	chk_skip_exec: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		do_skip |=> ##1 exec_insn_o == IDLE_OP)
		else $error("skipped word shown as executed");
	chk_flush_out: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$past(rstn_i) |-> flush_o == flushing)
		else $error("flush output disagrees with state");
	chk_idle_quiet: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		flushing |-> !rf_we && !acc_we && !is_jump)
		else $error("discarded word had an effect");
	chk_skip_flags: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		is_incskip && !stat_we_i |=> status == $past(status))
		else $error("skip changed flags");
endmodule : bix_exec

/* File: bix_pkg.sv */
// constants and types for the jump / increment execution block
package bix_pkg;
	localparam int PC_W = 11;
	localparam int DATA_W = 8;
	localparam int INSN_W = 12;
	localparam int FADDR_W = 5;
	localparam int NREGS = 32;
	// opcode patterns
	localparam logic [2:0] OPC_JUMP = 3'h5;
	localparam int OPC_JUMP_POS = 9;
	localparam logic [5:0] OPC_INC = 6'h0A;
	localparam logic [5:0] OPC_INCSKIP = 6'h0F;
	localparam int OPC6_POS = 6;
	localparam int DEST_POS = 5;
	localparam int LIT_W = 9;
	// status register fields
	localparam int STAT_ZERO_POS = 2;
	localparam int STAT_PAGE_LO = 5;
	localparam int STAT_PAGE_HI = 6;
	// reset values
	localparam logic [PC_W-1:0] PC_RESET = 11'h7FF;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] STAT_RESET = 8'h18;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam logic [INSN_W-1:0] IDLE_OP = 12'h000;
	// execution states
	typedef enum logic [1:0] {
		BIX_RUN = 2'b01,
		BIX_FLUSH = 2'b10
	} bix_state_t;
endpackage : bix_pkg

/* File: bix_regfile.sv */
// small file register memory with registered read data
`timescale 1ns/1ps
module bix_regfile #(
	parameter int DEPTH = 32,
	parameter int AW = 5,
	parameter int DW = 8
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// read port
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o,
	// write port
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i
);
	import bix_pkg::*;
	logic [DW-1:0] mem [DEPTH];

	// one storage word per entry, cleared with the core so results are known
	for (genvar i = 0; i < DEPTH; i++) begin : g_word
		always_ff @(posedge mclk_i) begin
			if (!rstn_i) begin
				mem[i] <= DW'(REG_RESET);
			end else if (we_i && waddr_i == AW'(i)) begin
				mem[i] <= wdata_i;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		rdata_o <= (we_i && waddr_i == raddr_i) ? wdata_i : mem[raddr_i];
	end
endmodule : bix_regfile

/* File: bix_exec_tb.sv */
// self-checking bench for the jump / increment execution block
`timescale 1ns/1ps
module bix_exec_tb;
	import bix_pkg::*;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic stat_we_i = 1'b0;
	logic [7:0] stat_wdata_i = 8'h00;
	logic [11:0] insn_i = 12'h000;
	logic [10:0] program_counter_o, m_pc;
	logic [7:0] acc_o, status_o, m_acc, m_st, r;
	logic [7:0] mem [32];
	logic [11:0] exec_insn_o, m_ir, m_ex, w;
	logic flush_o, m_fl;
	int errors = 0, checked = 0, warm = 0;
	bix_exec bix_exec_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .insn_i(insn_i), .program_counter_o(program_counter_o),
		.stat_we_i(stat_we_i), .stat_wdata_i(stat_wdata_i), .acc_o(acc_o), .status_o(status_o),
		.exec_insn_o(exec_insn_o), .flush_o(flush_o));
	initial forever #12.5 mclk_i = ~mclk_i;
	////////////////////////////////////////////////////////////////
	task chk(input logic [11:0] g, input logic [11:0] e);
		checked++;
		if ($isunknown(e) || g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task give_verdict;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task put(input logic [11:0] wd, input logic we);
		@(posedge mclk_i);
		insn_i <= wd;
		stat_we_i <= we;
		stat_wdata_i <= 8'($urandom);
	endtask : put
	////////////////////////////////////////////////////////////////
	// reference model, one executed word per edge
	always @(posedge mclk_i) begin
		if (!rstn_i) begin
			m_pc = PC_RESET;
			m_acc = ACC_RESET;
			m_st = STAT_RESET;
			m_ex = IDLE_OP;
			m_ir = IDLE_OP;
			m_fl = 1'b1;
			foreach (mem[i]) mem[i] = REG_RESET;
			warm = 0;
		end else begin : step
			logic [11:0] e;
			e = m_fl ? IDLE_OP : m_ir;
			m_fl = 1'b0;
			m_pc = m_pc + 11'h001;
			if (e[11:9] == OPC_JUMP) begin
				m_pc = {m_st[STAT_PAGE_HI:STAT_PAGE_LO], e[8:0]};
				m_fl = 1'b1;
			end else if (e[11:6] == OPC_INC || e[11:6] == OPC_INCSKIP) begin
				r = mem[e[4:0]] + 8'h01;
				if (e[DEST_POS]) mem[e[4:0]] = r;
				else m_acc = r;
				if (e[11:6] == OPC_INC) m_st[STAT_ZERO_POS] = (r == 8'h00);
				else m_fl = (r == 8'h00);
			end
			if (stat_we_i) m_st = stat_wdata_i;
			m_ex = e;
			m_ir = insn_i;
			warm = warm + 1;
		end
	end
	// compare between edges, once the model has seen two executed words
	always @(negedge mclk_i) if (rstn_i && warm > 1) begin
		chk(12'(program_counter_o), 12'(m_pc));
		chk(12'(acc_o), 12'(m_acc));
		chk(12'(status_o), 12'(m_st));
		chk(exec_insn_o, m_ex);
		chk(12'(flush_o), 12'(m_fl));
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h2B2B));
		repeat (10) @(posedge mclk_i);
		rstn_i <= 1'b1;
		for (int f = 0; f < 32; f++) put({OPC_INC, 1'b0, 5'(f)}, 1'b0);
		repeat (3) put(IDLE_OP, 1'b0);
		repeat (8'hFF - mem[3]) put({OPC_INC, 1'b1, 5'h03}, 1'b0);
		repeat (3) put(IDLE_OP, 1'b0);
		put({OPC_INC, 1'b0, 5'h03}, 1'b0);
		put({OPC_INCSKIP, 1'b1, 5'h03}, 1'b0);
		put({OPC_JUMP, 9'h0AA}, 1'b0);
		put({OPC_INCSKIP, 1'b0, 5'h03}, 1'b0);
		put({OPC_JUMP, 9'h1FF}, 1'b1);
		put({OPC_JUMP, 9'h000}, 1'b0);
		repeat (400) begin
			case ($urandom % 3)
				0: w = {OPC_JUMP, 9'($urandom)};
				1: w = {OPC_INC, 6'($urandom)};
				default: w = {OPC_INCSKIP, 6'($urandom)};
			endcase
			put(w, ($urandom % 6) == 0);
		end
		repeat (3) put(IDLE_OP, 1'b0);
		give_verdict();
	end
	initial begin
		#100000;
		errors++;
		give_verdict();
	end
endmodule : bix_exec_tb
